//--- core/ebpm_cfg.svh
`ifndef EBPM_CFG_SVH
`define EBPM_CFG_SVH

// ---------------------------------------------------------------
// register location and layout
// ---------------------------------------------------------------
`define EBPM_ADDR     16'h1C00
`define EBPM_RESET    16'h0000
`define EBPM_WR_MASK  16'h7F3F
`define EBPM_RSV_BIT  15
`define EBPM_PP_MSB   14
`define EBPM_PP_LSB   12
`define EBPM_SP1_MSB  11
`define EBPM_SP1_LSB  10
`define EBPM_SP0_MSB  9
`define EBPM_SP0_LSB  8
`define EBPM_AM_MSB   5
`define EBPM_AM_LSB   0

// ---------------------------------------------------------------
// pin group sizes
// ---------------------------------------------------------------
`define EBPM_PP_PINS  21
`define EBPM_PP_SRCS  6
`define EBPM_SP_PINS  6
`define EBPM_SP_SRCS  3
`define EBPM_SP_PORTS 2
`define EBPM_AM_PINS  6

`endif

//--- core/ebpm_pkg.sv
package ebpm_pkg;

  // ---------------------------------------------------------------
  // parallel port sources, index into the source arrays
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    pp_lcd  = 3'h0,
    pp_spi  = 3'h1,
    pp_uart = 3'h2,
    pp_i2s2 = 3'h3,
    pp_i2s3 = 3'h4,
    pp_gpio = 3'h5,
    pp_none = 3'h6
  } ebpm_pp_src_type;

  // serial port sources
  typedef enum logic [1:0] {
    sp_mmc  = 2'h0,
    sp_i2s  = 2'h1,
    sp_gpio = 2'h2,
    sp_none = 2'h3
  } ebpm_sp_src_type;

  // owner of a parallel port pin for a mode code; unlisted pins float
  function automatic ebpm_pp_src_type ebpm_pp_owner(input logic [2:0] mode, input int pin);
    ebpm_pp_src_type own;
    own = pp_none;
    case (mode)
      3'h0: own = pp_lcd;
      3'h1: own = (pin < 7) ? pp_spi : (pin < 13) ? pp_gpio : (pin < 17) ? pp_uart : pp_i2s2;
      3'h2: own = (pin < 8) ? pp_lcd : (pin < 16) ? pp_gpio : pp_none;
      3'h3: own = (pin < 8) ? pp_lcd : (pin < 12) ? pp_spi : (pin < 16) ? pp_i2s3 : pp_none;
      3'h4: own = (pin < 8) ? pp_lcd : (pin < 12) ? pp_i2s2 : (pin < 16) ? pp_uart : pp_none;
      3'h5: own = (pin < 8) ? pp_lcd : (pin < 12) ? pp_spi : (pin < 16) ? pp_uart : pp_none;
      3'h6: own = (pin < 7) ? pp_spi : (pin < 11) ? pp_i2s2 : (pin < 15) ? pp_i2s3 : pp_gpio;
      default: own = pp_none;
    endcase
    return own;
  endfunction

  // owner of a serial port pin; reserved code leaves the port undriven
  function automatic ebpm_sp_src_type ebpm_sp_owner(input logic [1:0] mode, input int pin);
    ebpm_sp_src_type own;
    own = sp_none;
    case (mode)
      2'h0: own = sp_mmc;
      2'h1: own = (pin < 4) ? sp_i2s : sp_gpio;
      2'h2: own = sp_gpio;
      default: own = sp_none;
    endcase
    return own;
  endfunction

endpackage

//--- core/ebpm_sp_if.sv
`timescale 1ns/1ps
// one serial port pin group between the top and its mux
interface ebpm_sp_if #(
  parameter int N = 6
);
  logic [1:0]        mode;
  logic [N-1:0]      pin_in;
  logic [N-1:0]      pin_out;
  logic [N-1:0]      pin_oe;
  logic [2:0][N-1:0] src_out;
  logic [2:0][N-1:0] src_oe;
  logic [2:0][N-1:0] src_in;

  modport mux (
    input  mode,
    input  pin_in,
    input  src_out,
    input  src_oe,
    output pin_out,
    output pin_oe,
    output src_in
  );
  modport top (
    output mode,
    output pin_in,
    output src_out,
    output src_oe,
    input  pin_out,
    input  pin_oe,
    input  src_in
  );
endinterface

//--- core/ebpm_sp_mux.sv
`timescale 1ns/1ps
`include "ebpm_cfg.svh"
// routes one six-pin serial port to memory card, audio serial or gpio
module ebpm_sp_mux #(
  parameter int PINS = `EBPM_SP_PINS,
  parameter int SRCS = `EBPM_SP_SRCS
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  ebpm_sp_if.mux    sp
);

  // ---------------------------------------------------------------
  // per-pin routing
  // ---------------------------------------------------------------
  for (genvar p = 0; p < PINS; p++) begin : g_pin
    ebpm_pkg::ebpm_sp_src_type own;
    assign own = ebpm_pkg::ebpm_sp_owner(sp.mode, p); // [R11] [R12]
    // reserved code drives nothing rather than guessing an owner
    assign sp.pin_out[p] = (own == ebpm_pkg::sp_none) ? 1'b0 : sp.src_out[own][p]; // [R2]
    assign sp.pin_oe[p]  = (own == ebpm_pkg::sp_none) ? 1'b0 : sp.src_oe[own][p];  // [R2]
    for (genvar s = 0; s < SRCS; s++) begin : g_src
      // only the owner sees the pin; others read a quiet zero
      assign sp.src_in[s][p] =
        (own == ebpm_pkg::ebpm_sp_src_type'(2'(s))) ? sp.pin_in[p] : 1'b0; // [R2]
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_sp_mmc;
    (sp.mode == 2'h0) |-> (sp.pin_out == sp.src_out[0]) && (sp.pin_oe == sp.src_oe[0]);
  endproperty
  a_sp_mmc: assert property (p_sp_mmc) else $error("memory card mode misrouted"); // [R12]

  property p_sp_i2s;
    (sp.mode == 2'h1) |->
      (sp.pin_out[3:0] == sp.src_out[1][3:0]) && (sp.pin_out[5:4] == sp.src_out[2][5:4]);
  endproperty
  a_sp_i2s: assert property (p_sp_i2s) else $error("audio serial mode misrouted"); // [R11]

  property p_sp_rsvd;
    (sp.mode == 2'h3) |-> (sp.pin_oe == '0) && (sp.src_in == '0);
  endproperty
  a_sp_rsvd: assert property (p_sp_rsvd) else $error("reserved serial mode drives"); // [R2]

  c_sp_gpio: cover property (sp.mode == 2'h2 && sp.pin_oe != '0);
endmodule

//--- core/ebpm_top.sv
`timescale 1ns/1ps
`include "ebpm_cfg.svh"
// Functional notes
// R1: register selects parallel port pin owners
// R2: register selects serial port 0/1 owners
// R3: register sits at io port 0x1C00
// R4: new routing applies next cpu cycle
// R5: per-bit address pins 20:15 gpio or address
// R6: software gates peripheral clocks before change
// R7: software resets affected peripherals after change
// R8: software writes register once after boot
// R9: bit 15 reads zero, ignores writes
// R10: bits 14:12 pick parallel port grouping
// R11: bits 11:10 pick serial port 1 use
// R12: bits 9:8 pick serial port 0 use
// R13: reset clears fields; bits 7:6 read zero
module ebpm_top #(
  parameter int PP_PINS = `EBPM_PP_PINS,
  parameter int PP_SRCS = `EBPM_PP_SRCS,
  parameter int SP_PINS = `EBPM_SP_PINS,
  parameter int SP_SRCS = `EBPM_SP_SRCS,
  parameter int AM_PINS = `EBPM_AM_PINS
) (
  input  wire logic                                 i_clk,
  input  wire logic                                 i_rst,
  // cpu io port
  input  wire logic [15:0]                          i_io_addr,
  input  wire logic                                 i_io_wr,
  input  wire logic                                 i_io_rd,
  input  wire logic [15:0]                          i_io_wdata,
  output logic      [15:0]                          o_io_rdata,
  // parallel port: sources lcd, spi, uart, i2s2, i2s3, gpio
  input  wire logic [PP_SRCS-1:0][PP_PINS-1:0]      i_pp_src_out,
  input  wire logic [PP_SRCS-1:0][PP_PINS-1:0]      i_pp_src_oe,
  output logic      [PP_SRCS-1:0][PP_PINS-1:0]      o_pp_src_in,
  input  wire logic [PP_PINS-1:0]                   i_pp_pin_in,
  output logic      [PP_PINS-1:0]                   o_pp_pin_out,
  output logic      [PP_PINS-1:0]                   o_pp_pin_oe,
  // serial ports 0/1: sources mmc, i2s, gpio
  input  wire logic [1:0][SP_SRCS-1:0][SP_PINS-1:0] i_sp_src_out,
  input  wire logic [1:0][SP_SRCS-1:0][SP_PINS-1:0] i_sp_src_oe,
  output logic      [1:0][SP_SRCS-1:0][SP_PINS-1:0] o_sp_src_in,
  input  wire logic [1:0][SP_PINS-1:0]              i_sp_pin_in,
  output logic      [1:0][SP_PINS-1:0]              o_sp_pin_out,
  output logic      [1:0][SP_PINS-1:0]              o_sp_pin_oe,
  // upper external memory address pins 20:15
  input  wire logic [AM_PINS-1:0]                   i_am_addr_out,
  input  wire logic [AM_PINS-1:0]                   i_am_addr_oe,
  input  wire logic [AM_PINS-1:0]                   i_am_gpio_out,
  input  wire logic [AM_PINS-1:0]                   i_am_gpio_oe,
  output logic      [AM_PINS-1:0]                   o_am_gpio_in,
  input  wire logic [AM_PINS-1:0]                   i_am_pin_in,
  output logic      [AM_PINS-1:0]                   o_am_pin_out,
  output logic      [AM_PINS-1:0]                   o_am_pin_oe
);

  localparam int SYNC_W = PP_PINS + 2 * SP_PINS + AM_PINS;

  logic [15:0]        route_r;
  logic [15:0]        route_nxt;
  logic [15:0]        rdata_r;
  logic               sel_hit;
  logic [SYNC_W-1:0]  pin_raw;
  logic [SYNC_W-1:0]  sync1_r;
  logic [SYNC_W-1:0]  sync2_r;
  logic [SYNC_W-1:0]  sync3_r;
  logic [SYNC_W-1:0]  pin_f_r;
  logic [PP_PINS-1:0] pp_in_f;
  logic [2:0]         pp_mode;
  logic [AM_PINS-1:0] am_mode;

  // ---------------------------------------------------------------
  // selection register
  // ---------------------------------------------------------------
  assign sel_hit = (i_io_addr == `EBPM_ADDR); // [R3]
  // reserved bits are masked out so they can never hold a one
  assign route_nxt = i_io_wdata & `EBPM_WR_MASK; // [R9] [R13]

  // written value drives the muxes from the following cycle on
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      route_r <= `EBPM_RESET; // [R13]
    end else if (i_io_wr && sel_hit) begin
      route_r <= route_nxt; // [R4]
    end
  end

  // read data one cycle after the strobe; idle and misses read zero
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_r <= `EBPM_RESET;
    end else begin
      rdata_r <= (i_io_rd && sel_hit) ? route_r : `EBPM_RESET; // [R13]
    end
  end
  assign o_io_rdata = rdata_r;

  assign pp_mode = route_r[`EBPM_PP_MSB:`EBPM_PP_LSB]; // [R10]
  assign am_mode = route_r[`EBPM_AM_MSB:`EBPM_AM_LSB]; // [R5]

  // ---------------------------------------------------------------
  // pin input synchronisers
  // ---------------------------------------------------------------
  assign pin_raw = {i_am_pin_in, i_sp_pin_in, i_pp_pin_in};

  // fourth stage filters: a bit moves only when stages two and three agree
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      pin_f_r <= '0;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      pin_f_r <= (sync2_r & sync3_r) | (pin_f_r & (sync2_r ^ sync3_r));
    end
  end
  assign pp_in_f = pin_f_r[PP_PINS-1:0];

  // ---------------------------------------------------------------
  // parallel port routing
  // ---------------------------------------------------------------
  // output paths stay combinational so a new mode shows one edge after the write
  for (genvar p = 0; p < PP_PINS; p++) begin : g_pp
    ebpm_pkg::ebpm_pp_src_type own;
    assign own = ebpm_pkg::ebpm_pp_owner(pp_mode, p); // [R10]
    assign o_pp_pin_out[p] = (own == ebpm_pkg::pp_none) ? 1'b0 : i_pp_src_out[own][p]; // [R1]
    assign o_pp_pin_oe[p]  = (own == ebpm_pkg::pp_none) ? 1'b0 : i_pp_src_oe[own][p];  // [R1]
    for (genvar s = 0; s < PP_SRCS; s++) begin : g_src
      assign o_pp_src_in[s][p] =
        (own == ebpm_pkg::ebpm_pp_src_type'(3'(s))) ? pp_in_f[p] : 1'b0; // [R1]
    end
  end

  // ---------------------------------------------------------------
  // serial ports
  // ---------------------------------------------------------------
  for (genvar k = 0; k < `EBPM_SP_PORTS; k++) begin : g_sp
    ebpm_sp_if #(.N(SP_PINS)) sp ();
    assign sp.mode    = (k == 0) ? route_r[`EBPM_SP0_MSB:`EBPM_SP0_LSB]
                                 : route_r[`EBPM_SP1_MSB:`EBPM_SP1_LSB]; // [R11] [R12]
    assign sp.pin_in  = pin_f_r[PP_PINS + k * SP_PINS +: SP_PINS];
    assign sp.src_out = i_sp_src_out[k];
    assign sp.src_oe  = i_sp_src_oe[k];
    assign o_sp_pin_out[k] = sp.pin_out;
    assign o_sp_pin_oe[k]  = sp.pin_oe;
    assign o_sp_src_in[k]  = sp.src_in;
    ebpm_sp_mux #(
      .PINS (SP_PINS),
      .SRCS (SP_SRCS)
    ) u_sp (
      .i_clk (i_clk),
      .i_rst (i_rst),
      .sp    (sp)
    );
  end

  // ---------------------------------------------------------------
  // address pins: one bit per pin, one selects gpio
  // ---------------------------------------------------------------
  // the address bus is output only, so only gpio ever sees the pin
  assign o_am_pin_out = (am_mode & i_am_gpio_out) | (~am_mode & i_am_addr_out); // [R5]
  assign o_am_pin_oe  = (am_mode & i_am_gpio_oe)  | (~am_mode & i_am_addr_oe);  // [R5]
  assign o_am_gpio_in = am_mode & pin_f_r[SYNC_W-1 -: AM_PINS];                 // [R5]

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_write;
    (i_io_wr && i_io_addr == `EBPM_ADDR) |=> (route_r == ($past(i_io_wdata) & `EBPM_WR_MASK));
  endproperty
  a_write: assert property (p_write) else $error("write not applied next cycle"); // [R4]

  property p_miss;
    (i_io_wr && i_io_addr != `EBPM_ADDR) |=> $stable(route_r);
  endproperty
  a_miss: assert property (p_miss) else $error("other address changed register"); // [R3]

  property p_rsvd;
    !o_io_rdata[`EBPM_RSV_BIT] && (o_io_rdata[7:6] == 2'h0);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero"); // [R9]

  property p_read;
    (i_io_rd && i_io_addr == `EBPM_ADDR && !i_io_wr) |=> (o_io_rdata == $past(route_r));
  endproperty
  a_read: assert property (p_read) else $error("read returned wrong value"); // [R13]

  property p_reset;
    @(posedge i_clk) disable iff (1'b0) $past(i_rst) |-> (route_r == `EBPM_RESET);
  endproperty
  a_reset: assert property (p_reset) else $error("reset did not clear register"); // [R13]

  property p_lcd_all;
    (pp_mode == 3'h0) |-> (o_pp_pin_out == i_pp_src_out[0]) && (o_pp_pin_oe == i_pp_src_oe[0]);
  endproperty
  a_lcd_all: assert property (p_lcd_all) else $error("mode 0 not all lcd"); // [R10]

  property p_pp_mode1;
    (pp_mode == 3'h1) |->
      (o_pp_pin_out[6:0] == i_pp_src_out[1][6:0]) &&
      (o_pp_pin_out[20:17] == i_pp_src_out[3][20:17]);
  endproperty
  a_pp_mode1: assert property (p_pp_mode1) else $error("mode 1 misrouted"); // [R1]

  property p_addr_gpio;
    (i_io_wr && i_io_addr == `EBPM_ADDR && i_io_wdata[0]) ##1 !(i_io_wr)
      |-> (o_am_pin_out[0] == i_am_gpio_out[0]);
  endproperty
  a_addr_gpio: assert property (p_addr_gpio) else $error("address pin not gpio"); // [R5]

  c_write: cover property (i_io_wr && i_io_addr == `EBPM_ADDR);
  c_mode6: cover property (pp_mode == 3'h6);
  c_read:  cover property (i_io_rd && i_io_addr == `EBPM_ADDR);
endmodule

//--- verif/ebpm_periph_model.sv
`timescale 1ns/1ps
// peripherals and board behind the shared pins; drive changes every cycle
module ebpm_periph_model (
  input  wire logic                 i_clk,
  input  wire logic                 i_quiet,
  input  wire logic [20:0]          i_pp_ext,
  input  wire logic [1:0][5:0]      i_sp_ext,
  input  wire logic [5:0]           i_am_ext,
  input  wire logic [20:0]          i_pp_out,
  input  wire logic [20:0]          i_pp_oe,
  input  wire logic [1:0][5:0]      i_sp_out,
  input  wire logic [1:0][5:0]      i_sp_oe,
  input  wire logic [5:0]           i_am_out,
  input  wire logic [5:0]           i_am_oe,
  output logic      [5:0][20:0]     o_pp_src_out = '0,
  output logic      [5:0][20:0]     o_pp_src_oe = '0,
  output logic      [1:0][2:0][5:0] o_sp_src_out = '0,
  output logic      [1:0][2:0][5:0] o_sp_src_oe = '0,
  output logic      [1:0][5:0]      o_am_src_out = '0,
  output logic      [1:0][5:0]      o_am_src_oe = '0,
  output logic      [20:0]          o_pp_pin,
  output logic      [1:0][5:0]      o_sp_pin,
  output logic      [5:0]           o_am_pin
);
  // fresh values each cycle so a stale route cannot pass; quiet releases all
  always @(negedge i_clk) begin
    for (int s = 0; s < 6; s++) begin
      o_pp_src_out[s] <= 21'($urandom);
      o_pp_src_oe[s]  <= i_quiet ? 21'h0 : 21'($urandom);
    end
    for (int k = 0; k < 2; k++) begin
      o_am_src_out[k] <= 6'($urandom);
      o_am_src_oe[k]  <= i_quiet ? 6'h0 : 6'($urandom);
      for (int s = 0; s < 3; s++) begin
        o_sp_src_out[k][s] <= 6'($urandom);
        o_sp_src_oe[k][s]  <= i_quiet ? 6'h0 : 6'($urandom);
      end
    end
  end
  // wire level: device drive where enabled, else the board's own driver
  assign o_pp_pin = (i_pp_oe & i_pp_out) | (~i_pp_oe & i_pp_ext);
  assign o_sp_pin = (i_sp_oe & i_sp_out) | (~i_sp_oe & i_sp_ext);
  assign o_am_pin = (i_am_oe & i_am_out) | (~i_am_oe & i_am_ext);
endmodule

//--- verif/test_external_bus_pin_mux.sv
`timescale 1ns/1ps
module test_external_bus_pin_mux;
  logic                 i_clk, i_rst, i_io_wr, i_io_rd, quiet;
  logic [15:0]          i_io_addr, i_io_wdata, o_io_rdata, cur, rv;
  logic [5:0][20:0]     pso, pse, psi;
  logic [20:0]          ppi, ppo, ppe, pext;
  logic [1:0][2:0][5:0] sso, sse, ssi;
  logic [1:0][5:0]      spi, spo, spe, sext, aso, ase;
  logic [5:0]           agi, api, apo, ape, aext;
  int                   fail_count, tests_run;

  ebpm_top dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_io_addr(i_io_addr), .i_io_wr(i_io_wr),
    .i_io_rd(i_io_rd), .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata),
    .i_pp_src_out(pso), .i_pp_src_oe(pse), .o_pp_src_in(psi), .i_pp_pin_in(ppi),
    .o_pp_pin_out(ppo), .o_pp_pin_oe(ppe), .i_sp_src_out(sso), .i_sp_src_oe(sse),
    .o_sp_src_in(ssi), .i_sp_pin_in(spi), .o_sp_pin_out(spo), .o_sp_pin_oe(spe),
    .i_am_addr_out(aso[0]), .i_am_addr_oe(ase[0]), .i_am_gpio_out(aso[1]),
    .i_am_gpio_oe(ase[1]), .o_am_gpio_in(agi), .i_am_pin_in(api), .o_am_pin_out(apo),
    .o_am_pin_oe(ape));
  ebpm_periph_model periph_u (.i_clk(i_clk), .i_quiet(quiet), .i_pp_ext(pext),
    .i_sp_ext(sext), .i_am_ext(aext), .i_pp_out(ppo), .i_pp_oe(ppe), .i_sp_out(spo),
    .i_sp_oe(spe), .i_am_out(apo), .i_am_oe(ape), .o_pp_src_out(pso), .o_pp_src_oe(pse),
    .o_sp_src_out(sso), .o_sp_src_oe(sse), .o_am_src_out(aso), .o_am_src_oe(ase),
    .o_pp_pin(ppi), .o_sp_pin(spi), .o_am_pin(api));

  // ---------------------------------------------------------------
  // expectations
  // ---------------------------------------------------------------
  // parallel pin owner: 0 lcd, 1 spi, 2 uart, 3/4 audio, 5 gpio, 6 undriven
  function automatic int pp_own(input logic [2:0] m, input int p);
    case (m)
      3'h0: return 0;
      3'h1: return (p < 7) ? 1 : (p < 13) ? 5 : (p < 17) ? 2 : 3;
      3'h2: return (p < 8) ? 0 : (p < 16) ? 5 : 6;
      3'h3: return (p < 8) ? 0 : (p < 12) ? 1 : (p < 16) ? 4 : 6;
      3'h4: return (p < 8) ? 0 : (p < 12) ? 3 : (p < 16) ? 2 : 6;
      3'h5: return (p < 8) ? 0 : (p < 12) ? 1 : (p < 16) ? 2 : 6;
      3'h6: return (p < 7) ? 1 : (p < 11) ? 3 : (p < 15) ? 4 : 5;
      default: return 6;
    endcase
  endfunction
  // serial pin owner: 0 card, 1 audio, 2 gpio, 3 undriven
  function automatic int sp_own(input logic [1:0] m, input int p);
    return (m == 2'h0) ? 0 : (m == 2'h1) ? ((p < 4) ? 1 : 2) : (m == 2'h2) ? 2 : 3;
  endfunction

  task automatic check(input logic [127:0] got, input logic [127:0] exp, input string w);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t %s got %0h exp %0h", $time, w, got, exp);
    end
  endtask

  // pin drive and pin-to-source paths for register value r
  task automatic check_pins(input logic [15:0] r, input bit ins);
    logic [20:0]          eo, ee;
    logic [1:0][5:0]      so, se;
    logic [5:0][20:0]     pi;
    logic [1:0][2:0][5:0] si;
    int                   s;
    for (int p = 0; p < 21; p++) begin
      s = pp_own(r[14:12], p);
      eo[p] = (s < 6) ? pso[s][p] : 1'b0;
      ee[p] = (s < 6) ? pse[s][p] : 1'b0;
      for (int x = 0; x < 6; x++) pi[x][p] = (s == x) ? pext[p] : 1'b0;
    end
    for (int k = 0; k < 2; k++) begin
      for (int p = 0; p < 6; p++) begin
        s = sp_own(k ? r[11:10] : r[9:8], p);
        so[k][p] = (s < 3) ? sso[k][s][p] : 1'b0;
        se[k][p] = (s < 3) ? sse[k][s][p] : 1'b0;
        for (int x = 0; x < 3; x++) si[k][x][p] = (s == x) ? sext[k][p] : 1'b0;
      end
    end
    if (ins) begin
      check(psi, pi, "pp to source");
      check(ssi, si, "sp to source");
      check(agi, aext & r[5:0], "addr pin to gpio");
    end else begin
      check(ppo, eo, "pp out");
      check(ppe, ee, "pp oe");
      check(spo, so, "sp out");
      check(spe, se, "sp oe");
      check(apo, (r[5:0] & aso[1]) | (~r[5:0] & aso[0]), "addr out");
      check(ape, (r[5:0] & ase[1]) | (~r[5:0] & ase[0]), "addr oe");
    end
  endtask

  // ---------------------------------------------------------------
  // io port
  // ---------------------------------------------------------------
  task automatic io_rd(input logic [15:0] a, input logic [15:0] exp);
    @(negedge i_clk);
    i_io_rd   = 1'b1;
    i_io_addr = a;
    @(negedge i_clk);
    i_io_rd = 1'b0;
    check(o_io_rdata, exp, "read");
    @(negedge i_clk);
    check(o_io_rdata, 16'h0000, "rdata idle");
  endtask

  // write, then prove the old route holds until the edge and the new one after
  task automatic route(input logic [15:0] a, input logic [15:0] v);
    @(negedge i_clk);
    i_io_wr    = 1'b1;
    i_io_addr  = a;
    i_io_wdata = v;
    #1 check_pins(cur, 1'b0);
    @(negedge i_clk);
    i_io_wr = 1'b0;
    if (a == 16'h1C00) cur = v & 16'h7F3F;
    #1 check_pins(cur, 1'b0);
    // peripherals idle so only the board drives, then watch inputs arrive
    quiet = 1'b1;
    pext  = 21'($urandom);
    sext  = 12'($urandom);
    aext  = 6'($urandom);
    repeat (6) @(negedge i_clk);
    check_pins(cur, 1'b1);
    io_rd(16'h1C00, cur);
    // peripherals restart only after readback; off the edge the model samples
    #1 quiet = 1'b0;
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge i_clk);
    fail_count++;
    $display("ERROR t=%0t run did not finish", $time);
    end_of_test();
  end

  initial begin
    {i_rst, i_io_wr, i_io_rd, quiet} = 4'h8;
    {i_io_addr, i_io_wdata, cur} = '0;
    {pext, sext, aext} = '0;
    void'($urandom(24275));
    repeat (10) @(negedge i_clk);
    i_rst = 1'b0;
    #1 check_pins(16'h0000, 1'b0);
    io_rd(16'h1C00, 16'h0000);
    $display("test reset done");
    route(16'h1C00, 16'hFFFF);
    route(16'h1C01, 16'h5A5A);
    io_rd(16'h1C01, 16'h0000);
    $display("test register done");
    // every parallel and serial code, then random values
    // each route switches live: peripherals keep driving across the write and go quiet only after it
    for (int i = 0; i < 16; i++) begin
      rv = 16'($urandom);
      if (i < 8) rv[14:8] = {3'(i), ~2'(i), 2'(i)};
      route(16'h1C00, rv);
    end
    $display("test routing done");
    end_of_test();
  end
endmodule
